// [supply_sequencing_engine.sv]
// Summary of operation
// [R1] each dual-function input runs as low-range fault detector or as logic input
// [R2] logic mode moves its detector to rail one..four or high-voltage rail as warning
// [R3] secondary detector shares rail range and reports warning, not failure
// [R4] warnings readable in status and ORed into one state machine input
// [R5] level mode: logic block output follows the filtered input
// [R6] edge mode: one pulse after chosen edge, width 0 to 100 us
// [R7] logic inputs use the same glitch filter as the fault detectors
// [R8] filter blocks pulses shorter than timeout, passes longer ones delayed
// [R9] each output picks state machine, bus bit or internal clock as data
// [R10] an internal 100 kHz clock can drive any output selecting it
// [R11] drive modes per output; charge pump only on outputs one to six
// [R12] outputs weakly low until latched, actively low once a rail reaches 1 V
// [R13] 63 programmable states, any state may reach any other
// [R14] every state watches all ten filtered input statuses
// [R15] sequence, monitor and timeout exits each with own condition and target
// [R16] sequence and timeout delays per state up to 400 ms, reloaded on change
// [R17] each state fixes all ten output levels while it lasts
// [R18] a transition including the state download finishes within 20 us
// [R19] ADC and secondary warnings ORed into one term for all three exits
// [R20] bus jump command forces advance through sequence and timeout paths
// [R21] timeout exit taken if its condition holds when the delay expires
// [R22] monitor exit is a wide OR of deviations, with no delay
// [R23] sequence exit waits a programmable delay before progressing
// [R24] priority: monitor over timeout over sequence
// [R25] one clock; reset puts machine in first state with outputs low
//
// Local design decisions: the plain strobed port and the placing of the registers.
`include "supply_seq_params.svh"
`default_nettype none
module supply_sequencing_engine
  import supply_seq_pkg::*;
#(
  parameter int N_DUAL = 5,
  parameter int N_OUT = 10,
  parameter int N_STATES = 63,
  parameter int N_PUMP = 6,
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  input wire logic [4:0] i_rail_fault,
  input wire logic [N_DUAL-1:0] i_dual_function_input,
  input wire logic [N_DUAL-1:0] i_dual_detect,
  input wire logic i_adc_warning,
  input wire logic i_rail_ge_1v,
  output logic [N_OUT-1:0] o_pdo_level,
  output logic [N_OUT-1:0] o_pdo_oe,
  output logic [N_OUT-1:0] o_pdo_weak_pullup,
  output logic [N_OUT-1:0] o_pdo_weak_pulldown,
  output logic [N_OUT-1:0] o_pdo_strong_pd,
  output logic [N_OUT-1:0] o_pdo_pump
);
  localparam int N_SE = 11;
  localparam int N_FILT = 15;
  localparam int MEM_DEPTH = N_STATES * `ENT_WORDS;

  // true when at least one input is selected and every selected input sits at its programmed level
  function automatic logic all_match(input logic [N_SE-1:0] mask, input logic [N_SE-1:0] pol,
                                     input logic [N_SE-1:0] in);
    all_match = (|mask) & (&(~mask | ~(in ^ pol)));
  endfunction

  // true when any selected input deviates from its programmed level
  function automatic logic any_dev(input logic [N_SE-1:0] mask, input logic [N_SE-1:0] pol,
                                   input logic [N_SE-1:0] in);
    any_dev = |(mask & (in ^ pol));
  endfunction

  logic [31:0] mem [0:MEM_DEPTH-1];
  logic latched_r, jump_pend_r;
  logic [N_DUAL-1:0] logic_mode_r, edge_mode_r, fall_r;
  logic [6:0] glitch_us_r, pulse_us_r;
  logic [5:0] out_cfg_r [0:N_OUT-1];
  logic [6:0] us_cnt_r;
  logic us_tick_r;
  logic [3:0] se_div_r;
  logic se_tick_r;
  logic [8:0] clk_div_r;
  logic pdo_clk_r;
  logic [N_FILT-1:0] raw;
  logic [N_FILT-1:0] filt_r;
  logic [6:0] fcnt_r [0:N_FILT-1];
  logic [N_DUAL-1:0] prev_r, pulse_r;
  logic [6:0] pcnt_r [0:N_DUAL-1];
  logic warn_r;
  logic [N_SE-1:0] se_in;
  se_phase_type phase_r;
  logic [5:0] state_r;
  logic [2:0] word_r;
  logic [N_OUT-1:0] lvl_r, lvl_stage_r;
  logic [5:0] tgt_seq_r, tgt_tmo_r, tgt_mon_r;
  logic [N_SE-1:0] seq_mask_r, seq_pol_r, tmo_mask_r, tmo_pol_r, mon_mask_r, mon_pol_r;
  logic [15:0] seq_dly_r, tmo_dly_r, seq_cnt_r, tmo_cnt_r;
  logic seq_cond, tmo_cond, mon_fire, tmo_fire, seq_fire;
  logic jump_wr, tbl_hit, reg_space;
  logic [N_OUT-1:0] src_val, push_sel;
  drive_mode_type drv_sel [0:N_OUT-1];
  logic [8:0] tbl_idx;
  logic [31:0] ent_word;

  // bus decode
  assign tbl_hit = i_addr[`TABLE_SEL_BIT] && (int'(i_addr[10:0]) < MEM_DEPTH);
  assign reg_space = !i_addr[`TABLE_SEL_BIT];
  assign tbl_idx = i_addr[8:0];
  assign jump_wr = i_wr && reg_space && i_addr == `REG_CTRL && i_wr_data[`CTRL_JUMP];
  assign ent_word = mem[{state_r, word_r}];

  // state table storage, written by software as the nonvolatile image
  always_ff @(posedge i_clk) begin
    if (i_wr && tbl_hit) begin
      mem[tbl_idx] <= i_wr_data;
    end
  end

  // configuration registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      latched_r <= 1'b0;
      logic_mode_r <= '0;
      edge_mode_r <= '0;
      fall_r <= '0;
      glitch_us_r <= '0;
      pulse_us_r <= '0;
      for (int n = 0; n < N_OUT; n++) begin
        out_cfg_r[n] <= '0;
      end
    end else if (i_wr && reg_space) begin
      if (i_addr == `REG_CTRL) begin
        latched_r <= i_wr_data[`CTRL_LATCHED]; // R12
      end
      if (i_addr == `REG_DUAL) begin
        logic_mode_r <= i_wr_data[`DUAL_LOGIC_LSB +: N_DUAL]; // R1
        edge_mode_r <= i_wr_data[`DUAL_EDGE_LSB +: N_DUAL];
        fall_r <= i_wr_data[`DUAL_FALL_LSB +: N_DUAL];
      end
      if (i_addr == `REG_TIMING) begin
        glitch_us_r <= i_wr_data[`TIM_GLITCH_LSB +: 7];
        pulse_us_r <= i_wr_data[`TIM_PULSE_LSB +: 7];
      end
      for (int n = 0; n < N_OUT; n++) begin
        if (i_addr == `REG_OUT_BASE + 12'(n)) begin
          out_cfg_r[n] <= i_wr_data[5:0]; // R9
        end
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data <= '0;
    end else if (!i_rd) begin
      o_rd_data <= '0;
    end else if (tbl_hit) begin
      o_rd_data <= mem[tbl_idx];
    end else if (!reg_space) begin
      o_rd_data <= '0;
    end else if (i_addr == `REG_CTRL) begin
      o_rd_data <= {30'h0000_0000, jump_pend_r, latched_r};
    end else if (i_addr == `REG_DUAL) begin
      o_rd_data <= {17'h0_0000, fall_r, edge_mode_r, logic_mode_r};
    end else if (i_addr == `REG_TIMING) begin
      o_rd_data <= {17'h0_0000, pulse_us_r, 1'b0, glitch_us_r};
    end else if (i_addr == `REG_STATUS) begin
      o_rd_data <= {9'h000, phase_r != PH_RUN, state_r, warn_r, filt_r[14:10],
                    se_in[9:0]}; // R4
    end else if (i_addr >= `REG_OUT_BASE && i_addr < `REG_OUT_BASE + 12'(N_OUT)) begin
      o_rd_data <= {26'h000_0000, out_cfg_r[4'(i_addr - `REG_OUT_BASE)]};
    end else begin
      o_rd_data <= '0;
    end
  end

  // microsecond and ten-microsecond enables, 100 kHz output clock
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      us_cnt_r <= '0;
      us_tick_r <= 1'b0;
      se_div_r <= '0;
      se_tick_r <= 1'b0;
      clk_div_r <= '0;
      pdo_clk_r <= 1'b0;
    end else begin
      us_tick_r <= us_cnt_r == 7'(`US_DIV - 1);
      us_cnt_r <= (us_cnt_r == 7'(`US_DIV - 1)) ? 7'h00 : us_cnt_r + 7'h01;
      se_tick_r <= us_tick_r && se_div_r == 4'(`SE_TICK_US - 1);
      if (us_tick_r) begin
        se_div_r <= (se_div_r == 4'(`SE_TICK_US - 1)) ? 4'h0 : se_div_r + 4'h1;
      end
      if (clk_div_r == 9'(`PDO_CLK_HALF - 1)) begin
        clk_div_r <= '0;
        pdo_clk_r <= ~pdo_clk_r; // R10
      end else begin
        clk_div_r <= clk_div_r + 9'h001;
      end
    end
  end

  // filter inputs: rails, dual inputs, secondary warning detectors
  always_comb begin
    for (int i = 0; i < N_DUAL; i++) begin
      raw[i] = i_rail_fault[i];
      raw[N_DUAL + i] = logic_mode_r[i] ? i_dual_function_input[i] : i_dual_detect[i]; // R1
      raw[2 * N_DUAL + i] = logic_mode_r[i] & i_dual_detect[i]; // R2 R3
    end
  end

  // glitch filters: output follows only after input held for the timeout
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      filt_r <= '0;
      for (int i = 0; i < N_FILT; i++) begin
        fcnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_FILT; i++) begin
        if (raw[i] == filt_r[i]) begin
          fcnt_r[i] <= '0; // R8
        end else if (fcnt_r[i] >= glitch_us_r) begin
          filt_r[i] <= raw[i]; // R7 R8
          fcnt_r[i] <= '0;
        end else if (us_tick_r) begin
          fcnt_r[i] <= fcnt_r[i] + 7'h01;
        end
      end
    end
  end

  // edge detection pulse generators for logic-mode inputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_r <= '0;
      pulse_r <= '0;
      for (int i = 0; i < N_DUAL; i++) begin
        pcnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_DUAL; i++) begin
        prev_r[i] <= filt_r[N_DUAL + i];
        if (fall_r[i] ? (prev_r[i] & ~filt_r[N_DUAL + i])
                      : (~prev_r[i] & filt_r[N_DUAL + i])) begin
          pulse_r[i] <= 1'b1; // R6
          pcnt_r[i] <= '0;
        end else if (pulse_r[i]) begin
          if (pcnt_r[i] >= pulse_us_r) begin
            pulse_r[i] <= 1'b0;
          end else if (us_tick_r) begin
            pcnt_r[i] <= pcnt_r[i] + 7'h01;
          end
        end
      end
    end
  end

  // combined warning from adc limits and secondary detectors
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      warn_r <= 1'b0;
    end else begin
      warn_r <= i_adc_warning | (|filt_r[N_FILT-1:2*N_DUAL]); // R4 R19
    end
  end

  // inputs seen by the state machine
  always_comb begin
    se_in[4:0] = filt_r[4:0]; // R14
    for (int i = 0; i < N_DUAL; i++) begin
      se_in[N_DUAL + i] = (logic_mode_r[i] & edge_mode_r[i]) ? pulse_r[i]
                                                             : filt_r[N_DUAL + i]; // R5
    end
    se_in[N_SE-1] = warn_r; // R19
  end

  // exit conditions of the current state
  assign seq_cond = all_match(seq_mask_r, seq_pol_r, se_in);
  assign tmo_cond = all_match(tmo_mask_r, tmo_pol_r, se_in);
  assign mon_fire = any_dev(mon_mask_r, mon_pol_r, se_in); // R22
  assign tmo_fire = (tmo_cond && tmo_cnt_r >= tmo_dly_r) || jump_pend_r; // R21 R20
  assign seq_fire = (seq_cond && seq_cnt_r >= seq_dly_r) || jump_pend_r; // R23 R20

  // jump request: a new command wins over the clear of an old one
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      jump_pend_r <= 1'b0;
    end else if (jump_wr) begin
      jump_pend_r <= 1'b1; // R20
    end else if (phase_r == PH_RUN) begin
      jump_pend_r <= 1'b0;
    end
  end

  // sequence engine: download a state entry, then run its three exits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_r <= PH_HALT;
      state_r <= '0; // R25
      word_r <= '0;
      lvl_r <= '0;
      lvl_stage_r <= '0;
      {tgt_seq_r, tgt_tmo_r, tgt_mon_r} <= '0;
      {seq_mask_r, seq_pol_r, tmo_mask_r, tmo_pol_r, mon_mask_r, mon_pol_r} <= '0;
      {seq_dly_r, tmo_dly_r, seq_cnt_r, tmo_cnt_r} <= '0;
    end else begin
      unique case (phase_r)
        PH_HALT: begin
          word_r <= '0;
          if (latched_r) begin
            phase_r <= PH_LOAD;
          end
        end
        PH_LOAD: begin
          unique case (word_r)
            3'h0: begin
              lvl_stage_r <= ent_word[N_OUT-1:0];
              tgt_seq_r <= ent_word[`ENT_TGT_SEQ_LSB +: 6];
              tgt_tmo_r <= ent_word[`ENT_TGT_TMO_LSB +: 6];
              tgt_mon_r <= ent_word[`ENT_TGT_MON_LSB +: 6];
            end
            3'h1: {seq_pol_r, seq_mask_r} <= {ent_word[`ENT_POL_LSB +: N_SE], ent_word[N_SE-1:0]};
            3'h2: {tmo_pol_r, tmo_mask_r} <= {ent_word[`ENT_POL_LSB +: N_SE], ent_word[N_SE-1:0]};
            3'h3: {mon_pol_r, mon_mask_r} <= {ent_word[`ENT_POL_LSB +: N_SE], ent_word[N_SE-1:0]};
            3'h4: seq_dly_r <= ent_word[15:0]; // R16
            default: tmo_dly_r <= ent_word[15:0];
          endcase
          word_r <= word_r + 3'h1;
          if (word_r == `ENT_LAST_WORD) begin
            phase_r <= PH_RUN; // R18
            lvl_r <= lvl_stage_r; // R17
            seq_cnt_r <= '0; // R16
            tmo_cnt_r <= '0;
          end
        end
        PH_RUN: begin
          word_r <= '0;
          if (se_tick_r && tmo_cnt_r != 16'hffff) begin
            tmo_cnt_r <= tmo_cnt_r + 16'h0001;
          end
          if (!seq_cond) begin
            seq_cnt_r <= '0;
          end else if (se_tick_r && seq_cnt_r != 16'hffff) begin
            seq_cnt_r <= seq_cnt_r + 16'h0001;
          end
          if (mon_fire) begin
            state_r <= tgt_mon_r; // R24 R15
            phase_r <= PH_LOAD;
          end else if (tmo_fire && (|tmo_mask_r)) begin
            state_r <= tgt_tmo_r; // R24 R15
            phase_r <= PH_LOAD;
          end else if (seq_fire) begin
            state_r <= tgt_seq_r; // R13 R15
            phase_r <= PH_LOAD;
          end
        end
      endcase
    end
  end

  // per-output data source and effective drive mode
  always_comb begin
    for (int n = 0; n < N_OUT; n++) begin
      drv_sel[n] = drive_mode_type'(out_cfg_r[n][`OCFG_DRV_LSB +: 3]);
      if (drv_sel[n] == DRV_CHARGE_PUMP && n >= N_PUMP) begin
        drv_sel[n] = DRV_PUSH_PULL; // R11
      end
      push_sel[n] = drv_sel[n] == DRV_PUSH_PULL || drv_sel[n] == DRV_CHARGE_PUMP;
      unique case (out_source_type'(out_cfg_r[n][`OCFG_SRC_LSB +: 2]))
        SRC_SE: src_val[n] = lvl_r[n]; // R9
        SRC_BUS: src_val[n] = out_cfg_r[n][`OCFG_BUS_BIT];
        SRC_CLOCK: src_val[n] = pdo_clk_r; // R10
        default: src_val[n] = 1'b0;
      endcase
    end
  end

  // output drivers: source select, then drive mode
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pdo_level <= '0;
      o_pdo_oe <= '0;
      o_pdo_weak_pullup <= '0;
      o_pdo_weak_pulldown <= '1;
      o_pdo_strong_pd <= '0;
      o_pdo_pump <= '0;
    end else begin
      for (int n = 0; n < N_OUT; n++) begin
        o_pdo_weak_pulldown[n] <= !latched_r;
        if (!latched_r) begin
          o_pdo_level[n] <= 1'b0; // R12
          o_pdo_oe[n] <= i_rail_ge_1v;
          o_pdo_weak_pullup[n] <= 1'b0;
          o_pdo_strong_pd[n] <= 1'b0;
          o_pdo_pump[n] <= 1'b0;
        end else begin
          o_pdo_level[n] <= push_sel[n] && src_val[n]; // R11
          o_pdo_oe[n] <= push_sel[n] || !src_val[n];
          o_pdo_weak_pullup[n] <= drv_sel[n] == DRV_OD_WEAK_PU && src_val[n];
          o_pdo_strong_pd[n] <= drv_sel[n] == DRV_STRONG_PD && !src_val[n];
          o_pdo_pump[n] <= drv_sel[n] == DRV_CHARGE_PUMP && src_val[n];
        end
      end
    end
  end

endmodule // supply_sequencing_engine
`default_nettype wire

// [supply_seq_params.svh]
`ifndef SUPPLY_SEQ_PARAMS_SVH
`define SUPPLY_SEQ_PARAMS_SVH
// clock and time bases
`define CLK_PERIOD_NS 10
`define US_TICK_NS 1000
`define US_DIV (`US_TICK_NS / `CLK_PERIOD_NS)
`define SE_TICK_US 10
`define PDO_CLK_HZ 100000
`define CLK_HZ 100000000
`define PDO_CLK_HALF (`CLK_HZ / (2 * `PDO_CLK_HZ))
// filter and pulse limits in microseconds
`define GLITCH_MAX_US 100
`define PULSE_MAX_US 100
// register word indexes
`define REG_CTRL 12'h000
`define REG_DUAL 12'h001
`define REG_TIMING 12'h002
`define REG_STATUS 12'h003
`define REG_OUT_BASE 12'h004
`define TABLE_SEL_BIT 11
// control fields
`define CTRL_LATCHED 0
`define CTRL_JUMP 1
// dual-function input fields
`define DUAL_LOGIC_LSB 0
`define DUAL_EDGE_LSB 5
`define DUAL_FALL_LSB 10
// timing fields
`define TIM_GLITCH_LSB 0
`define TIM_PULSE_LSB 8
// output config fields
`define OCFG_SRC_LSB 0
`define OCFG_BUS_BIT 2
`define OCFG_DRV_LSB 3
// state table layout: eight words per state, six used
`define ENT_WORDS 8
`define ENT_LAST_WORD 3'h5
`define ENT_TGT_SEQ_LSB 10
`define ENT_TGT_TMO_LSB 16
`define ENT_TGT_MON_LSB 22
`define ENT_POL_LSB 11
// status fields
`define ST_WARN_LSB 10
`define ST_WARN_ALL 15
`define ST_STATE_LSB 16
`define ST_LOADING 22
`endif

// [supply_seq_pkg.sv]
`default_nettype none
package supply_seq_pkg;
  typedef enum logic [1:0] {SRC_SE, SRC_BUS, SRC_CLOCK} out_source_type;
  typedef enum logic [2:0] {
    DRV_OPEN_DRAIN, DRV_OD_WEAK_PU, DRV_PUSH_PULL, DRV_STRONG_PD, DRV_CHARGE_PUMP
  } drive_mode_type;
  typedef enum {PH_HALT, PH_LOAD, PH_RUN} se_phase_type;
endpackage
`default_nettype wire

// [supply_seq_asserts.sv]
`default_nettype none
module supply_seq_asserts #(
  parameter int N_OUT = 10,
  parameter int ADDR_W = 12
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rd_data,
  input wire logic i_rail_ge_1v,
  input wire logic [N_OUT-1:0] o_pdo_level,
  input wire logic [N_OUT-1:0] o_pdo_oe,
  input wire logic [N_OUT-1:0] o_pdo_weak_pullup,
  input wire logic [N_OUT-1:0] o_pdo_weak_pulldown,
  input wire logic [N_OUT-1:0] o_pdo_strong_pd,
  input wire logic [N_OUT-1:0] o_pdo_pump
);
  logic lat_r;
  logic [5:0] cfg_r;
  logic [2:0] age_r;
  logic [9:0] gap_r;
  logic seen_r;
  logic clk_mode;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // latch flag, output 0 setup and cycles since either was last written
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lat_r <= 1'b0;
      cfg_r <= 6'h00;
      age_r <= 3'h0;
    end else if (i_wr && (i_addr == 12'h000 || i_addr == 12'h004)) begin
      lat_r <= lat_r | (i_addr == 12'h000 && i_wr_data[0]);
      cfg_r <= (i_addr == 12'h004) ? i_wr_data[5:0] : cfg_r;
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  // output 0 settled on the internal clock, push-pull
  assign clk_mode = lat_r && age_r == 3'h7 && cfg_r == 6'h12;
  // cycles between edges of output 0, first edge only arms the check
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gap_r <= 10'h000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= $changed(o_pdo_level[0]) ? 10'h000 : gap_r + {9'h000, gap_r != 10'h3ff};
      seen_r <= clk_mode && (seen_r || $changed(o_pdo_level[0]));
    end
  end
  a_rd_slot_only: assert property (!i_rd |=> o_rd_data == 32'h0000_0000)
    else $error("read data outside its slot");
  a_rd_hole_zero: assert property (i_rd && (i_addr[11] ? i_addr[10:0] >= 11'h1f8 :
    i_addr >= 12'h00e) |=> o_rd_data == 32'h0000_0000) else $error("unmapped read not zero");
  a_pd_unlatched: assert property (!lat_r |-> &o_pdo_weak_pulldown && o_pdo_level == '0)
    else $error("outputs not weakly low before latch");
  a_no_drive_early: assert property (!lat_r |->
    (o_pdo_weak_pullup | o_pdo_strong_pd | o_pdo_pump) == '0) else $error("drive before latch");
  a_oe_follow_rail: assert property (!lat_r && $past(i_resetn) |->
    o_pdo_oe == {N_OUT{$past(i_rail_ge_1v)}}) else $error("enable not following rail level");
  a_pump_low_six: assert property (o_pdo_pump[N_OUT-1:6] == '0)
    else $error("charge pump on upper outputs");
  a_bus_src_pin: assert property (lat_r && age_r == 3'h7 && cfg_r[5:3] == 3'h2 &&
    cfg_r[1:0] == 2'h1 |-> o_pdo_level[0] == cfg_r[2] && o_pdo_oe[0])
    else $error("bus bit not on output");
  a_clk_half_period: assert property (seen_r && clk_mode && $changed(o_pdo_level[0])
    |-> gap_r == 10'h1f3) else $error("internal clock half period wrong");
endmodule // supply_seq_asserts
bind supply_sequencing_engine supply_seq_asserts #(.N_OUT(N_OUT), .ADDR_W(ADDR_W)) i_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
  .i_rd(i_rd), .o_rd_data(o_rd_data), .i_rail_ge_1v(i_rail_ge_1v), .o_pdo_level(o_pdo_level),
  .o_pdo_oe(o_pdo_oe), .o_pdo_weak_pullup(o_pdo_weak_pullup),
  .o_pdo_weak_pulldown(o_pdo_weak_pulldown), .o_pdo_strong_pd(o_pdo_strong_pd),
  .o_pdo_pump(o_pdo_pump));
`default_nettype wire

// [rail_model.sv]
`default_nettype none
module rail_model #(
  parameter int RISE = 300
) (
  input wire logic i_clk,
  input wire logic i_en,
  input wire logic [4:0] i_inject,
  output logic o_ge_1v,
  output logic [4:0] o_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  int pwr = 0;
  int ramp = 0;
  // bulk supply crosses 1 V a few cycles into the run
  always @(posedge i_clk) begin
    pwr <= (pwr < 8) ? pwr + 1 : pwr;
  end
  // high-voltage rail regulator ramps while enabled, collapses when disabled
  always @(posedge i_clk) begin
    ramp <= i_en ? ((ramp < RISE) ? ramp + 1 : ramp) : 0;
  end
  assign o_ge_1v = pwr >= 8;
  assign o_fault = i_inject | {ramp < RISE, 4'h0};
endmodule // rail_model
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m;} note_type;
  localparam logic [21:0] NONE = 22'h00_0000;
  logic i_clk, i_resetn, i_wr, i_rd, i_adc_warning, i_rail_ge_1v, look, rd_q;
  logic [11:0] i_addr;
  logic [31:0] i_wr_data, o_rd_data;
  logic [4:0] i_rail_fault, i_dual_function_input, i_dual_detect, inject;
  logic [9:0] lvl, oe, wpu, wpd, spd, pump;
  logic [6:0] g, p;
  int miscompares, tests_run;
  int unsigned r;
  note_type nq[$];
  note_type n;
  supply_sequencing_engine i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .i_rail_fault(i_rail_fault), .i_dual_function_input(i_dual_function_input),
    .i_dual_detect(i_dual_detect), .i_adc_warning(i_adc_warning), .i_rail_ge_1v(i_rail_ge_1v),
    .o_pdo_level(lvl), .o_pdo_oe(oe), .o_pdo_weak_pullup(wpu), .o_pdo_weak_pulldown(wpd),
    .o_pdo_strong_pd(spd), .o_pdo_pump(pump));
  rail_model i_rails (.i_clk(i_clk), .i_en(lvl[9]), .i_inject(inject),
    .o_ge_1v(i_rail_ge_1v), .o_fault(i_rail_fault));
  // clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge i_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, string nm);
    @(posedge i_clk);
    nq.push_back('{nm, e, m});
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic pins(input logic [31:0] e, input logic [31:0] m, string nm);
    @(posedge i_clk);
    nq.push_back('{nm, e, m});
    look <= 1'b1;
    @(posedge i_clk);
    look <= 1'b0;
  endtask
  task automatic st(input logic [5:0] s);
    rd(12'h003, {10'h000, s, 16'h0000}, 32'h007f_0000, "state");
  endtask
  function automatic logic [21:0] mp(input logic [10:0] m, input logic pol);
    return {pol ? m : 11'h000, m};
  endfunction
  task automatic ent(input logic [5:0] s, input logic [9:0] lv, input logic [5:0] ts, tt, tm,
      input logic [21:0] ms, mt, mm, input logic [15:0] ds, dt);
    logic [31:0] w[6];
    w = '{{4'h0, tm, tt, ts, lv}, {10'h000, ms}, {10'h000, mt}, {10'h000, mm}, {16'h0000, ds},
      {16'h0000, dt}};
    for (int i = 0; i < 6; i++) begin
      wr(12'h800 + {3'h0, s, 3'h0} + 12'(i), w[i]);
    end
  endtask
  // compare each result as it appears against the oldest note
  always @(posedge i_clk) begin
    rd_q <= i_rd;
    if (rd_q || look) begin
      n = nq.pop_front();
      check(n.nm, (rd_q ? o_rd_data : {2'h0, pump, wpu, lvl}) & n.m, n.e);
    end
  end
  // watchdog
  initial begin
    wt(40000);
    miscompares++;
    conclude();
  end
  // main sequence
  initial begin
    r = $urandom(32'h0000_d47d);
    {i_resetn, i_wr, i_rd, i_adc_warning, look} = 5'h00;
    {i_addr, i_wr_data, inject, i_dual_function_input, i_dual_detect} = '0;
    miscompares = 0;
    tests_run = 0;
    wt(3);
    i_resetn <= 1'b1;
    rd(12'h000, 32'h0000_0000, 32'hffff_ffff, "ctrl reset");
    rd(12'h003, 32'h0040_0000, 32'h007f_0000, "status reset");
    rd(12'h0ff, 32'h0000_0000, 32'hffff_ffff, "hole");
    rd(12'h9f8, 32'h0000_0000, 32'hffff_ffff, "table end");
    g = 7'($urandom_range(100));
    p = 7'($urandom_range(100));
    wr(12'h002, {17'h0_0000, p, 1'b0, g});
    rd(12'h002, {17'h0_0000, p, 1'b0, g}, 32'h0000_7f7f, "timing");
    wr(12'h002, 32'h0000_0a02);
    i_dual_detect <= 5'h02;
    wt(300);
    rd(12'h003, 32'h0000_0040, 32'h0000_ffe0, "analog detect");
    i_dual_detect <= 5'h00;
    for (int i = 0; i < 10; i++) begin
      wr(12'h004 + 12'(i), 32'h0000_0010);
    end
    ent(6'h00, 10'h001, 6'h01, 6'h02, 6'h03, mp(11'h002, 1), mp(11'h002, 1), mp(11'h002, 0), 0, 0);
    ent(6'h03, 10'h008, 6'h05, 6'h04, 6'h00, mp(11'h010, 0), mp(11'h010, 1), NONE, 0, 5);
    ent(6'h04, 10'h200, 6'h06, 6'h00, 6'h00, mp(11'h400, 1), NONE, NONE, 2, 0);
    ent(6'h06, 10'h040, 6'h07, 6'h00, 6'h00, mp(11'h040, 1), NONE, NONE, 0, 0);
    ent(6'h07, 10'h080, 6'h08, 6'h00, 6'h00, mp(11'h020, 1), NONE, NONE, 0, 0);
    ent(6'h08, 10'h100, 6'h09, 6'h00, 6'h00, mp(11'h020, 0), NONE, NONE, 0, 0);
    ent(6'h09, 10'h002, 6'h0a, 6'h00, 6'h00, mp(11'h020, 1), NONE, NONE, 0, 0);
    ent(6'h0a, 10'h004, 6'h0b, 6'h00, 6'h00, mp(11'h020, 0), NONE, NONE, 0, 0);
    ent(6'h0b, 10'h000, 6'h00, 6'h00, 6'h00, NONE, NONE, NONE, 0, 0);
    pins(32'h0000_0000, 32'h3fff_ffff, "pins unlatched");
    wr(12'h000, 32'h0000_0001);
    wt(20);
    st(6'h00);
    pins(32'h0000_0001, 32'h0000_03ff, "pins first state");
    inject <= 5'h02;
    wt(250);
    st(6'h03);
    pins(32'h0000_0008, 32'h0000_03ff, "pins monitor target");
    wt(2800);
    st(6'h03);
    wt(2600);
    st(6'h04);
    wr(12'h001, 32'h0000_0001);
    i_dual_detect <= 5'h01;
    wt(300);
    rd(12'h003, 32'h0000_8400, 32'h0000_fc00, "secondary warning");
    st(6'h04);
    wt(2500);
    st(6'h06);
    i_dual_detect <= 5'h00;
    i_adc_warning <= 1'b1;
    wt(300);
    rd(12'h003, 32'h0000_8000, 32'h0000_fc00, "adc warning");
    i_adc_warning <= 1'b0;
    wr(12'h000, 32'h0000_0003);
    wt(30);
    st(6'h07);
    i_dual_function_input <= 5'h01;
    wt(80);
    i_dual_function_input <= 5'h00;
    wt(300);
    st(6'h07);
    i_dual_function_input <= 5'h01;
    wt(400);
    st(6'h08);
    wr(12'h001, 32'h0000_0021);
    wt(1000);
    st(6'h09);
    i_dual_function_input <= 5'h00;
    wt(400);
    st(6'h09);
    i_dual_function_input <= 5'h01;
    wt(300);
    st(6'h0a);
    wt(1500);
    st(6'h0b);
    wr(12'h004, 32'h0000_0015);
    wr(12'h005, 32'h0000_000d);
    wr(12'h006, 32'h0000_0025);
    wr(12'h00b, 32'h0000_0025);
    wt(10);
    pins(32'h0000_0001, 32'h0000_0001, "bus source");
    pins(32'h0040_0885, 32'h0840_0887, "drive modes");
    wr(12'h004, 32'h0000_0012);
    wt(1600);
    conclude();
  end
endmodule // tb
`default_nettype wire
